// ===== pkg/pcm_pkg.sv
// constants shared by the clock mode and clock output block
package pcm_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam longint SYS_CLK_HZ       = 200_000_000;
  localparam longint PLL_LOCK_TIME_MS = 1;
  // least time, so round up
  localparam int unsigned PLL_LOCK_CYCLES = int'(
    (PLL_LOCK_TIME_MS * SYS_CLK_HZ + 999) / 1000);
  localparam int LOCK_CNT_W = 18;

  // ****************************************
  // clocking modes, caught from the select pins
  // ****************************************
  typedef enum logic [1:0] {
    PCM_DIV_TWO   = 2'b00,
    PCM_TIMES_ONE = 2'b01,
    PCM_TIMES_FOUR = 2'b11
  } pcm_mode_e;
  localparam logic [1:0] MODE_RESERVED = 2'h2;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] PDC_OFFSET  = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;

  // power divide control fields
  localparam int PDC_PS_EN_BIT  = 0;
  localparam int PDC_DIV_LSB    = 1;
  localparam int PDC_DIV_W      = 3;
  localparam int PDC_DRV_LSB    = 8;
  localparam int PDC_SRC_LSB    = 10;
  localparam logic [31:0] PDC_RESET = 32'h0000_0100;
  localparam logic [31:0] PDC_MASK  = 32'h0000_0F0F;

  // status fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_PLL_BIT  = 2;
  localparam int STAT_LOCK_BIT = 3;
  localparam int STAT_PS_BIT   = 4;

  // power-save divider counts fundamental falls
  localparam int PS_CNT_W = 8;
  localparam logic [PS_CNT_W-1:0] PS_CNT_ONE = 8'h01;

  // times-four phase measurement
  localparam int HALF_CNT_W = 16;
  localparam logic [1:0] X4_LAST_TICK = 2'h3;

endpackage

// ===== core/pcm_clk_out_gate.sv
// one clock output: source select and drive enable without runt phases
module pcm_clk_out_gate
  import pcm_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic fundLvl,
  input  wire logic fundNxt,
  input  wire logic cpuNxt,
  input  wire logic cpuLvl,
  input  wire logic selCpu,
  input  wire logic driveEn,
  output logic      clkOut,
  output logic      clkDriveEn
);

  logic curSel_r, curSel_nxt;
  logic curEn_r,  curEn_nxt;
  logic out_r,    out_nxt;
  logic fundFall, cpuFall, targetFall, curNxt;

  always_comb begin
    fundFall   = fundLvl & ~fundNxt;
    cpuFall    = cpuLvl & ~cpuNxt;
    targetFall = selCpu ? cpuFall : fundFall;
    curNxt     = curEn_r & (curSel_r ? cpuNxt : fundNxt);
    curSel_nxt = curSel_r;
    curEn_nxt  = curEn_r;
    // change only where the new source starts a low phase and the
    // old one is low too, so no phase is cut short
    if (targetFall && !curNxt) begin
      curSel_nxt = selCpu;
      curEn_nxt  = driveEn;
    end
    out_nxt = curEn_nxt & (curSel_nxt ? cpuNxt : fundNxt);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      curSel_r <= 1'b0;
      curEn_r  <= 1'b0;
      out_r    <= 1'b0;
    end else begin
      curSel_r <= curSel_nxt;
      curEn_r  <= curEn_nxt;
      out_r    <= out_nxt;
    end
  end

  assign clkOut     = out_r;
  assign clkDriveEn = curEn_r;

endmodule

// ===== core/pcm_clock_ctrl.sv
// clock mode, pll stand-in, power-save divider and two clock outputs
//
// Behaviour
// - divide-by-two keeps the pll off and runs the clock at half the input.
// - times-one turns the pll on and runs the clock at the input rate.
// - times-four turns the pll on and runs the clock at four times input.
// - the mode comes from the two select pins while reset is held.
// - each clock output carries the fundamental or the power-save clock.
// - the two outputs choose their source independently.
// - each output has its own drive enable.
// - after the pll starts, 1 ms passes before the clock counts as stable.
// - a hardware interrupt ends power-save; software ones do not.
module pcm_clock_ctrl
  import pcm_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = PLL_LOCK_CYCLES
)(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        oscillatorInput,
  input  wire logic        clockModeSelectA,
  input  wire logic        clockModeSelectB,
  input  wire logic        hwInterrupt,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             oscillatorOutput,
  output logic             pllEnable,
  output logic             pllLocked,
  output logic             primaryClockOutput,
  output logic             primaryClockDriveEn,
  output logic             secondaryClockOutput,
  output logic             secondaryClockDriveEn
);

  // ****************************************
  // mode capture and pll lock
  // ****************************************
  pcm_mode_e             mode_r, mode_nxt;
  logic                  pllEn_r, pllEn_nxt;
  logic                  locked_r, locked_nxt;
  logic [LOCK_CNT_W-1:0] lockCnt_r, lockCnt_nxt;
  logic                  oscOut_r, oscOut_nxt;
  logic [1:0]            pinMode;

  always_comb begin
    pinMode = {clockModeSelectB, clockModeSelectA};
    // reserved pin code falls back to the default times-four
    if (pinMode == MODE_RESERVED) begin
      mode_nxt = PCM_TIMES_FOUR;
    end else begin
      mode_nxt = pcm_mode_e'(pinMode);
    end
    pllEn_nxt   = (mode_r != PCM_DIV_TWO);
    lockCnt_nxt = lockCnt_r;
    locked_nxt  = locked_r;
    if (!pllEn_r) begin
      locked_nxt = (mode_r == PCM_DIV_TWO);
    end else if (!locked_r) begin
      if (lockCnt_r == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
        locked_nxt = 1'b1;
      end else begin
        lockCnt_nxt = lockCnt_r + 1'b1;
      end
    end
    oscOut_nxt = ~oscillatorInput;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      // pins are followed for as long as reset is held
      mode_r    <= mode_nxt;
      pllEn_r   <= 1'b0;
      locked_r  <= 1'b0;
      lockCnt_r <= '0;
      oscOut_r  <= 1'b0;
    end else begin
      mode_r    <= mode_r;
      pllEn_r   <= pllEn_nxt;
      locked_r  <= locked_nxt;
      lockCnt_r <= lockCnt_nxt;
      oscOut_r  <= oscOut_nxt;
    end
  end

  // ****************************************
  // fundamental clock synthesis
  // ****************************************
  logic                  oscPrev_r;
  logic                  fund_r, fund_nxt;
  logic [HALF_CNT_W-1:0] halfCnt_r, halfCnt_nxt;
  logic [HALF_CNT_W-1:0] halfLen_r, halfLen_nxt;
  logic [HALF_CNT_W-1:0] subCnt_r, subCnt_nxt;
  logic [1:0]            tick_r, tick_nxt;
  logic                  oscRise, oscEdge;
  logic [HALF_CNT_W-1:0] quarter;

  always_comb begin
    oscEdge     = oscillatorInput ^ oscPrev_r;
    oscRise     = oscillatorInput & ~oscPrev_r;
    quarter     = (halfLen_r >> 2) == '0 ? HALF_CNT_W'(1) : halfLen_r >> 2;
    fund_nxt    = fund_r;
    halfCnt_nxt = oscEdge ? '0 : halfCnt_r + 1'b1;
    halfLen_nxt = oscEdge ? halfCnt_r + 1'b1 : halfLen_r;
    subCnt_nxt  = subCnt_r;
    tick_nxt    = tick_r;
    unique case (mode_r)
      PCM_DIV_TWO: begin
        if (oscRise) begin
          fund_nxt = ~fund_r;
        end
      end
      PCM_TIMES_ONE: begin
        if (oscEdge) begin
          fund_nxt = ~fund_r;
        end
      end
      PCM_TIMES_FOUR: begin
        // four toggles per input half period from the measured length
        if (oscEdge) begin
          fund_nxt   = ~fund_r;
          subCnt_nxt = '0;
          tick_nxt   = '0;
        end else if (tick_r != X4_LAST_TICK &&
                     subCnt_r + 1'b1 >= quarter) begin
          fund_nxt   = ~fund_r;
          subCnt_nxt = '0;
          tick_nxt   = tick_r + 1'b1;
        end else begin
          subCnt_nxt = subCnt_r + 1'b1;
        end
      end
      default: begin
        fund_nxt = fund_r;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      oscPrev_r <= 1'b0;
      fund_r    <= 1'b0;
      halfCnt_r <= '0;
      halfLen_r <= '0;
      subCnt_r  <= '0;
      tick_r    <= '0;
    end else begin
      oscPrev_r <= oscillatorInput;
      fund_r    <= fund_nxt;
      halfCnt_r <= halfCnt_nxt;
      halfLen_r <= halfLen_nxt;
      subCnt_r  <= subCnt_nxt;
      tick_r    <= tick_nxt;
    end
  end

  // ****************************************
  // power-save cpu clock
  // ****************************************
  logic [31:0]         pdc_r, pdc_nxt;
  logic                psAct_r, psAct_nxt;
  logic                cpu_r, cpu_nxt;
  logic [PS_CNT_W-1:0] psCnt_r, psCnt_nxt;
  logic [PS_CNT_W-1:0] psLast;
  logic                fundFall, gatedFund, gatedFundNxt;

  always_comb begin
    // no fundamental or power-save clock leaves the block until the pll has settled
    gatedFund    = fund_r & locked_r;
    gatedFundNxt = fund_nxt & locked_nxt;
    fundFall     = gatedFund & ~gatedFundNxt;
    // last count of a cpu clock half period, in fundamental periods from zero
    psLast    = (PS_CNT_ONE << pdc_r[PDC_DIV_LSB +: PDC_DIV_W]) - PS_CNT_ONE;
    psAct_nxt = psAct_r;
    psCnt_nxt = psCnt_r;
    cpu_nxt   = cpu_r;
    if (!psAct_r) begin
      cpu_nxt = gatedFundNxt;
      // enter power-save only at a fall, both clocks low
      if (fundFall && pdc_r[PDC_PS_EN_BIT]) begin
        psAct_nxt = 1'b1;
        psCnt_nxt = '0;
      end
    end else if (fundFall) begin
      if (psCnt_r == psLast) begin
        psCnt_nxt = '0;
        cpu_nxt   = ~cpu_r;
        // leave only where the cpu clock falls with the fundamental
        if (cpu_r && !pdc_r[PDC_PS_EN_BIT]) begin
          psAct_nxt = 1'b0;
        end
      end else begin
        psCnt_nxt = psCnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      psAct_r <= 1'b0;
      psCnt_r <= '0;
      cpu_r   <= 1'b0;
    end else begin
      psAct_r <= psAct_nxt;
      psCnt_r <= psCnt_nxt;
      cpu_r   <= cpu_nxt;
    end
  end

  // ****************************************
  // apb slave, zero wait, registered answer
  // ****************************************
  logic        ready_r, ready_nxt;
  logic        err_r, err_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        setup, wrDone;

  always_comb begin
    setup     = psel & ~penable & ~ready_r;
    wrDone    = psel & penable & ready_r & pwrite & ~err_r;
    ready_nxt = setup;
    err_nxt   = err_r;
    rdata_nxt = rdata_r;
    pdc_nxt   = pdc_r;
    if (setup) begin
      rdata_nxt = 32'h0000_0000;
      err_nxt   = 1'b0;
      if (paddr == PDC_OFFSET) begin
        rdata_nxt = pdc_r;
      end else if (paddr == STAT_OFFSET) begin
        rdata_nxt[STAT_MODE_LSB +: 2] = mode_r;
        rdata_nxt[STAT_PLL_BIT]       = pllEn_r;
        rdata_nxt[STAT_LOCK_BIT]      = locked_r;
        rdata_nxt[STAT_PS_BIT]        = psAct_r;
      end else begin
        err_nxt = 1'b1;
      end
    end
    if (wrDone && paddr == PDC_OFFSET) begin
      pdc_nxt = pwdata & PDC_MASK;
    end
    // hardware interrupt beats a write that sets power-save
    if (hwInterrupt) begin
      pdc_nxt[PDC_PS_EN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ready_r <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
      pdc_r   <= PDC_RESET;
    end else begin
      ready_r <= ready_nxt;
      err_r   <= err_nxt;
      rdata_r <= rdata_nxt;
      pdc_r   <= pdc_nxt;
    end
  end

  // ****************************************
  // clock outputs
  // ****************************************
  logic [1:0] outClk, outEn;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_out
      pcm_clk_out_gate u_gate (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .fundLvl    (gatedFund),
        .fundNxt    (gatedFundNxt),
        .cpuNxt     (cpu_nxt),
        .cpuLvl     (cpu_r),
        .selCpu     (pdc_r[PDC_SRC_LSB + i]),
        .driveEn    (pdc_r[PDC_DRV_LSB + i]),
        .clkOut     (outClk[i]),
        .clkDriveEn (outEn[i])
      );
    end
  endgenerate

  assign pready                = ready_r;
  assign pslverr               = err_r;
  assign prdata                = rdata_r;
  assign oscillatorOutput      = oscOut_r;
  assign pllEnable             = pllEn_r;
  assign pllLocked             = locked_r;
  assign primaryClockOutput    = outClk[0];
  assign primaryClockDriveEn   = outEn[0];
  assign secondaryClockOutput  = outClk[1];
  assign secondaryClockDriveEn = outEn[1];

endmodule

// ===== verification/pcm_osc_model.sv
// free-running oscillator source feeding the clock block
module pcm_osc_model #(
  parameter int HALF = 8
)(
  input  wire logic clk_sys,
  output logic      oscOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // oscillator
  // ******
  // a crystal never stops, so the level keeps toggling between tests
  int cnt = 0;
  initial oscOut = 1'b0;
  always @(posedge clk_sys) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) oscOut <= ~oscOut;
  end
endmodule

// ===== verification/pcm_clock_ctrl_checker.sv
// assertion checker for the clock mode and clock output block
module pcm_clock_ctrl_checker
  import pcm_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = 20
)(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clockModeSelectA,
  input wire logic clockModeSelectB,
  input wire logic oscillatorInput,
  input wire logic oscillatorOutput,
  input wire logic pllEnable,
  input wire logic pllLocked,
  input wire logic primaryClockOutput,
  input wire logic primaryClockDriveEn,
  input wire logic secondaryClockOutput,
  input wire logic secondaryClockDriveEn
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // mode latch and cycles since release
  // ******
  localparam logic [15:0] LOCK16 = 16'(LOCK_CYCLES);
  logic [1:0]  mode_r, mode_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  always_comb begin
    mode_nxt = resetn ? mode_r : {clockModeSelectB, clockModeSelectA};
    cnt_nxt  = !resetn ? 16'h0000 : (&cnt_r ? cnt_r : cnt_r + 16'h0001);
  end
  always_ff @(posedge clk_sys) begin
    mode_r <= mode_nxt;
    cnt_r  <= cnt_nxt;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ******
  // assertions
  // ******
  chk_pll_mode: assert property (
    cnt_r > 16'h0003 |-> pllEnable == (mode_r != 2'h0))
    else $error("pll enable differs from latched mode");
  chk_lock_early: assert property (
    pllEnable && pllLocked |-> cnt_r >= LOCK16)
    else $error("pll lock reported too early");
  chk_lock_late: assert property (
    cnt_r == LOCK16 + 16'h0008 |-> pllLocked)
    else $error("lock not reported in time");
  // inverter output lags its input by one register
  chk_osc_inv: assert property (
    cnt_r != 16'h0000 |-> oscillatorOutput == !$past(oscillatorInput))
    else $error("oscillator output is not the inverted input");
  chk_out_quiet: assert property (
    !pllLocked |-> !primaryClockOutput && !secondaryClockOutput)
    else $error("clock output before lock");
  chk_pri_held: assert property (
    !primaryClockDriveEn |-> !primaryClockOutput)
    else $error("primary output active while not driven");
  chk_sec_held: assert property (
    !secondaryClockDriveEn |-> !secondaryClockOutput)
    else $error("secondary output active while not driven");
  // shortest legal phase with the bench oscillator is two cycles
  chk_pri_no_runt: assert property (
    $changed(primaryClockOutput) |=> $stable(primaryClockOutput))
    else $error("runt phase on primary output");
  chk_sec_no_runt: assert property (
    $changed(secondaryClockOutput) |=> $stable(secondaryClockOutput))
    else $error("runt phase on secondary output");
endmodule

bind pcm_clock_ctrl pcm_clock_ctrl_checker #(
  .LOCK_CYCLES(LOCK_CYCLES)
) pcm_clock_ctrl_checker_i (
  .clk_sys(clk_sys), .resetn(resetn),
  .clockModeSelectA(clockModeSelectA), .clockModeSelectB(clockModeSelectB),
  .oscillatorInput(oscillatorInput), .oscillatorOutput(oscillatorOutput),
  .pllEnable(pllEnable), .pllLocked(pllLocked),
  .primaryClockOutput(primaryClockOutput),
  .primaryClockDriveEn(primaryClockDriveEn),
  .secondaryClockOutput(secondaryClockOutput),
  .secondaryClockDriveEn(secondaryClockDriveEn)
);

// ===== verification/pcm_clock_ctrl_tb.sv
// self-checking testbench for the clock mode and clock output block
module pcm_clock_ctrl_tb
  import pcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // signals, design and partner
  // ******
  localparam int LOCK = 20;
  localparam int OSC_HALF = 8;
  typedef struct {
    logic [1:0] pins;
    logic       pll;
    logic [1:0] modeSt;
    int         half;
  } pcm_row_s;
  pcm_row_s rows [4] = '{'{2'h0, 1'b0, 2'h0, 2 * OSC_HALF},
    '{2'h1, 1'b1, 2'h1, OSC_HALF}, '{2'h3, 1'b1, 2'h3, OSC_HALF / 4},
    '{2'h2, 1'b1, 2'h3, OSC_HALF / 4}};
  logic        resetn = 1'b0, hwInterrupt = 1'b0, psel = 1'b0;
  logic        penable = 1'b0, pwrite = 1'b0;
  logic        clockModeSelectA = 1'b1, clockModeSelectB = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        clk_sys, oscIn, pready, pslverr, pllEnable, pllLocked;
  logic        primaryClockOutput, primaryClockDriveEn, err, measSec;
  logic        secondaryClockOutput, secondaryClockDriveEn, selOut;
  int          n_errors = 0, checks = 0, n, h;
  assign selOut = measSec ? secondaryClockOutput : primaryClockOutput;
  pcm_osc_model #(.HALF(OSC_HALF)) pcm_osc_model_i (
    .clk_sys(clk_sys), .oscOut(oscIn));
  pcm_clock_ctrl #(.LOCK_CYCLES(LOCK)) pcm_clock_ctrl_i (
    .clk_sys(clk_sys), .resetn(resetn), .oscillatorInput(oscIn),
    .clockModeSelectA(clockModeSelectA), .clockModeSelectB(clockModeSelectB),
    .hwInterrupt(hwInterrupt), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .oscillatorOutput(),
    .pllEnable(pllEnable), .pllLocked(pllLocked),
    .primaryClockOutput(primaryClockOutput),
    .primaryClockDriveEn(primaryClockDriveEn),
    .secondaryClockOutput(secondaryClockOutput),
    .secondaryClockDriveEn(secondaryClockDriveEn));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ******
  // tasks
  // ******
  task automatic check_ok(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic do_reset(input logic [1:0] pins);
    @(posedge clk_sys);
    resetn <= 1'b0;
    clockModeSelectA <= pins[0];
    clockModeSelectB <= pins[1];
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) check_ok(1'b0, "apb hang");
  endtask
  // high time of the chosen output, in clk_sys cycles
  task automatic meas(input logic sec);
    int k = 0;
    measSec = sec;
    h = 0;
    @(posedge clk_sys);
    while (selOut !== 1'b0 && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
    while (selOut !== 1'b1 && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
    while (selOut === 1'b1 && k < 400) begin
      @(posedge clk_sys);
      k++;
      h++;
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ******
  // tests
  // ******
  // four resets with lock waits take well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      do_reset(rows[i].pins);
      n = 0;
      while (pllLocked !== 1'b1 && n < LOCK + 50) begin
        @(posedge clk_sys);
        n++;
      end
      check_ok(pllLocked === 1'b1 && (n >= LOCK) == rows[i].pll, "lock");
      check_ok(pllEnable === rows[i].pll, "pll enable");
      meas(1'b0);
      check_ok(h == rows[i].half, "primary rate");
      check_ok(primaryClockDriveEn === 1'b1 &&
        secondaryClockDriveEn === 1'b0, "drive at reset");
      apb(1'b0, PDC_OFFSET, 32'h0000_0000);
      check_ok(rd === PDC_RESET, "control reset value");
      apb(1'b0, STAT_OFFSET, 32'h0000_0000);
      check_ok(rd[2:0] === {rows[i].pll, rows[i].modeSt}, "status");
    end
    apb(1'b1, PDC_OFFSET, 32'h0000_0B01);
    repeat (40) @(posedge clk_sys);
    apb(1'b0, STAT_OFFSET, 32'h0000_0000);
    check_ok(rd[STAT_PS_BIT] === 1'b1, "power-save on");
    meas(1'b0);
    check_ok(h == OSC_HALF / 4, "primary fundamental");
    meas(1'b1);
    check_ok(h == OSC_HALF / 2, "secondary power-save");
    hwInterrupt <= 1'b1;
    @(posedge clk_sys);
    hwInterrupt <= 1'b0;
    repeat (40) @(posedge clk_sys);
    apb(1'b0, PDC_OFFSET, 32'h0000_0000);
    check_ok(rd === 32'h0000_0B00, "interrupt ends power-save");
    meas(1'b1);
    check_ok(h == OSC_HALF / 4, "secondary back to normal");
    apb(1'b1, PDC_OFFSET, 32'h0000_0A00);
    repeat (20) @(posedge clk_sys);
    check_ok(primaryClockDriveEn === 1'b0 &&
      secondaryClockDriveEn === 1'b1, "drive swap");
    apb(1'b0, 8'h08, 32'h0000_0000);
    check_ok(err === 1'b1 && rd === 32'h0000_0000, "unmapped read");
    apb(1'b1, STAT_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, STAT_OFFSET, 32'h0000_0000);
    check_ok(rd[1:0] === 2'h3, "status read-only");
    tally_and_finish();
  end
endmodule
